/* File: src/serc_regs.svh */
// serc register offsets, field positions, reset values and counts
// assumes 7-bit register addresses and 9-bit register data
`ifndef SERC_REGS_SVH
`define SERC_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SERC_ADDR_MASK        7'h25
`define SERC_ADDR_SEL_A       7'h26
`define SERC_ADDR_SEL_B       7'h27
`define SERC_ADDR_SEL_C       7'h28
`define SERC_ADDR_SEL_D       7'h29

// ----------------------------------------
// reset values
// ----------------------------------------
`define SERC_RST_MASK         9'h000
`define SERC_RST_SEL_A        9'h010
`define SERC_RST_SEL_B        9'h032
`define SERC_RST_SEL_C        9'h054
`define SERC_RST_SEL_D        9'h006

// ----------------------------------------
// field positions
// ----------------------------------------
`define SERC_BIT_CONCEAL_SEL  8
`define SERC_BIT_PASS_MARKED  8
`define SERC_MSK_INVALID      1
`define SERC_MSK_CORRUPT      3
`define SERC_MSK_AUDIO_N      4
`define SERC_MSK_PCM_N        5

// ----------------------------------------
// pin selector codes and counts
// ----------------------------------------
`define SERC_SEL_LAST_OUT     4'hd
`define SERC_SEL_CMOS_IN      4'he
`define SERC_SEL_COMP_IN      4'hf
`define SERC_SYNC_LAST        3'd5
`define SERC_SYNC_ZEROS       3'd4
`define SERC_BURST_HOLD       13'd4096

`endif

/* File: src/serc_pkg.sv */
// serc types shared by the concealment block and its testbench
// assumes all producers run on clk_sys
package serc_pkg;

  typedef struct packed {
    logic [23:0] data;
    logic        left;
    logic        corrupt;
    logic        invalid;
  } serc_sub_s;

  typedef struct packed {
    logic [23:0] data;
    logic        left;
  } serc_pcm_s;

  typedef struct packed {
    logic v;
    logic u;
    logic c;
    logic p;
    logic subframe_strobe;
    logic block_start_marker;
    logic unlock;
    logic chan_status_update;
    logic zero_detect;
    logic copy_permit_low;
    logic preemphasis_seen;
  } serc_stat_s;

endpackage

/* File: src/serc_pin_mux.sv */
// serc_pin_mux: one status output pin with registered selection
// assumes src and sel are on clk_sys
`timescale 1ns/100ps
`include "serc_regs.svh"

module serc_pin_mux
#(
  parameter bit INPUT_CAPABLE = 1'b0
)
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [3:0]  sel,
  input  wire logic [13:0] src,
  output logic             pin_out,
  output logic             pin_oe,
  output logic             cmos_in,
  output logic             comp_in
);

  logic next_pin_out;
  logic next_pin_oe;
  logic next_cmos_in;
  logic next_comp_in;

  always_comb
  begin
    next_pin_out = (sel > `SERC_SEL_LAST_OUT) ? 1'b0 : src[sel];
    next_cmos_in = INPUT_CAPABLE && (sel == `SERC_SEL_CMOS_IN);
    next_comp_in = INPUT_CAPABLE && (sel == `SERC_SEL_COMP_IN);
    next_pin_oe  = !(next_cmos_in || next_comp_in);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b1;
      cmos_in <= 1'b0;
      comp_in <= 1'b0;
    end
    else
    begin
      pin_out <= next_pin_out;
      pin_oe  <= next_pin_oe;
      cmos_in <= next_cmos_in;
      comp_in <= next_comp_in;
    end
  end

endmodule

/* File: src/serc_conceal.sv */
// serc_conceal: error concealment, non-audio detect and status pins
// assumes recovered sub-frames and status arrive on clk_sys
`timescale 1ns/100ps
`include "serc_regs.svh"

module serc_conceal
  import serc_pkg::*;
#(
  parameter logic [15:0] SYNC_PA = 16'ha5a5,
  parameter logic [15:0] SYNC_PB = 16'h5a5a,
  parameter logic [12:0] BURST_HOLD = `SERC_BURST_HOLD
)
(
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       reg_wr_en,
  input  wire logic [6:0] reg_addr,
  input  wire logic [8:0] reg_wr_data,
  output logic [8:0]      reg_rd_data,
  input  wire logic       sf_in_valid,
  input  wire serc_sub_s  sf_in,
  input  wire serc_stat_s stat_in,
  input  wire logic       cs_nonaudio,
  input  wire logic       first_dac_from_rx,
  input  wire logic       int_clear,
  output logic            aud_valid,
  output serc_pcm_s       aud_out,
  output logic            tx_valid,
  output serc_pcm_s       tx_out,
  output logic            first_dac_softmute,
  output logic            nonpcm_status,
  output logic            burst_sync,
  output logic            int_n,
  output logic [6:0]      gpo_out,
  output logic [6:0]      gpo_oe,
  output logic [2:0]      rx_cmos_in_en,
  output logic [2:0]      rx_comp_in_en
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [8:0]  mask, sel_a, sel_b, sel_c, sel_d;
  logic [8:0]  next_mask, next_sel_a, next_sel_b, next_sel_c, next_sel_d;
  logic [8:0]  next_rd_data;

  always_comb
  begin
    next_mask  = mask;
    next_sel_a = sel_a;
    next_sel_b = sel_b;
    next_sel_c = sel_c;
    next_sel_d = sel_d;
    if (reg_wr_en)
    begin
      case (reg_addr)
        `SERC_ADDR_MASK:  next_mask  = reg_wr_data;
        `SERC_ADDR_SEL_A: next_sel_a = reg_wr_data;
        `SERC_ADDR_SEL_B: next_sel_b = reg_wr_data;
        `SERC_ADDR_SEL_C: next_sel_c = reg_wr_data;
        `SERC_ADDR_SEL_D: next_sel_d = reg_wr_data;
        default:          next_mask  = mask;
      endcase
    end
    case (reg_addr)
      `SERC_ADDR_MASK:  next_rd_data = mask;
      `SERC_ADDR_SEL_A: next_rd_data = sel_a;
      `SERC_ADDR_SEL_B: next_rd_data = sel_b;
      `SERC_ADDR_SEL_C: next_rd_data = sel_c;
      `SERC_ADDR_SEL_D: next_rd_data = sel_d;
      default:          next_rd_data = 9'h000;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      mask        <= `SERC_RST_MASK;
      sel_a       <= `SERC_RST_SEL_A;
      sel_b       <= `SERC_RST_SEL_B;
      sel_c       <= `SERC_RST_SEL_C;
      sel_d       <= `SERC_RST_SEL_D;
      reg_rd_data <= 9'h000;
    end
    else
    begin
      mask        <= next_mask;
      sel_a       <= next_sel_a;
      sel_b       <= next_sel_b;
      sel_c       <= next_sel_c;
      sel_d       <= next_sel_d;
      reg_rd_data <= next_rd_data;
    end
  end

  logic conceal_select, pass_marked_samples;
  assign conceal_select      = sel_a[`SERC_BIT_CONCEAL_SEL];
  assign pass_marked_samples = sel_b[`SERC_BIT_PASS_MARKED];

  // ----------------------------------------
  // concealment and event logic
  // ----------------------------------------
  logic [23:0] held [2], next_held [2];
  logic [23:0] held_sel;
  logic [15:0] word, expect_word;
  logic [12:0] hold_cnt, next_hold_cnt;
  logic [2:0]  match_cnt, next_match_cnt, pending, next_pending, ev;
  logic        aud_hide, tx_hide, clean, found, next_nonpcm, next_burst;
  logic        next_aud_valid, next_tx_valid, next_softmute, next_int_n;
  serc_pcm_s   next_aud_out, next_tx_out;

  always_comb
  begin
    held_sel = held[sf_in.left];
    // corrupt and invalid are the two damage markers of a sub-frame
    aud_hide = (sf_in.corrupt && mask[`SERC_MSK_CORRUPT])
             || (sf_in.invalid && mask[`SERC_MSK_INVALID] && !pass_marked_samples);
    tx_hide  = sf_in.invalid && mask[`SERC_MSK_INVALID] && !pass_marked_samples;
    clean    = !sf_in.corrupt && !sf_in.invalid;
    next_held = held;
    if (sf_in_valid && clean)
      next_held[sf_in.left] = sf_in.data;
    next_aud_valid    = sf_in_valid;
    next_tx_valid     = sf_in_valid;
    next_aud_out.left = sf_in.left;
    next_tx_out.left  = sf_in.left;
    // unmasked flags pass the sample untouched
    next_aud_out.data = sf_in.data;
    next_tx_out.data  = sf_in.data;
    if (aud_hide)
      next_aud_out.data = conceal_select ? 24'h000000 : held_sel;
    if (tx_hide)
      next_tx_out.data = conceal_select ? 24'h000000 : held_sel;
    if (!sf_in_valid)
    begin
      next_aud_out = aud_out;
      next_tx_out  = tx_out;
    end

    // sync search: four zero words then the two preamble words
    word = sf_in.data[23:8];
    case (match_cnt)
      `SERC_SYNC_ZEROS: expect_word = SYNC_PA;
      `SERC_SYNC_LAST:  expect_word = SYNC_PB;
      default:          expect_word = 16'h0000;
    endcase
    found          = 1'b0;
    next_match_cnt = match_cnt;
    if (sf_in_valid)
    begin
      if (word == expect_word)
      begin
        found          = (match_cnt == `SERC_SYNC_LAST);
        next_match_cnt = found ? 3'd0 : match_cnt + 3'd1;
      end
      else if (word == 16'h0000)
        next_match_cnt = (match_cnt == `SERC_SYNC_ZEROS) ? match_cnt : 3'd1;
      else
        next_match_cnt = 3'd0;
    end
    next_hold_cnt = hold_cnt;
    next_burst    = burst_sync;
    if (stat_in.unlock)
    begin
      next_hold_cnt  = 13'd0;
      next_burst     = 1'b0;
      next_match_cnt = 3'd0;
    end
    else if (found)
    begin
      next_hold_cnt = BURST_HOLD;
      next_burst    = 1'b1;
    end
    else if (sf_in_valid && hold_cnt != 13'd0)
    begin
      next_hold_cnt = hold_cnt - 13'd1;
      next_burst    = (hold_cnt != 13'd1);
    end
    next_nonpcm = stat_in.chan_status_update ? cs_nonaudio : nonpcm_status;

    // events: unmasked sources only, set beats clear
    ev[0] = sf_in_valid && sf_in.invalid && !mask[`SERC_MSK_INVALID];
    ev[1] = sf_in_valid && sf_in.corrupt && !mask[`SERC_MSK_CORRUPT];
    ev[2] = ((next_nonpcm != nonpcm_status) && !mask[`SERC_MSK_AUDIO_N])
          || ((next_burst != burst_sync) && !mask[`SERC_MSK_PCM_N]);
    next_pending  = (pending & ~{3{int_clear}}) | ev;
    next_int_n    = ~|next_pending;
    next_softmute = first_dac_from_rx && (next_nonpcm || next_burst);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      held               <= '{24'h000000, 24'h000000};
      aud_valid          <= 1'b0;
      tx_valid           <= 1'b0;
      aud_out            <= '0;
      tx_out             <= '0;
      match_cnt          <= 3'd0;
      hold_cnt           <= 13'd0;
      burst_sync         <= 1'b0;
      nonpcm_status      <= 1'b0;
      pending            <= 3'd0;
      int_n              <= 1'b1;
      first_dac_softmute <= 1'b0;
    end
    else
    begin
      held               <= next_held;
      aud_valid          <= next_aud_valid;
      tx_valid           <= next_tx_valid;
      aud_out            <= next_aud_out;
      tx_out             <= next_tx_out;
      match_cnt          <= next_match_cnt;
      hold_cnt           <= next_hold_cnt;
      burst_sync         <= next_burst;
      nonpcm_status      <= next_nonpcm;
      pending            <= next_pending;
      int_n              <= next_int_n;
      first_dac_softmute <= next_softmute;
    end
  end

  // ----------------------------------------
  // status pins
  // ----------------------------------------
  logic [13:0] src;
  logic [3:0]  pin_sel [7];
  logic [6:0]  cmos_all, comp_all;

  // source order follows the selector codes
  assign src = {stat_in.preemphasis_seen, stat_in.copy_permit_low,
                nonpcm_status || burst_sync, stat_in.zero_detect, sf_in.invalid,
                stat_in.chan_status_update, stat_in.unlock, stat_in.block_start_marker,
                stat_in.subframe_strobe, stat_in.p, stat_in.c, stat_in.u, stat_in.v,
                int_n};
  assign pin_sel[0] = sel_a[3:0];
  assign pin_sel[1] = sel_a[7:4];
  assign pin_sel[2] = sel_b[3:0];
  assign pin_sel[3] = sel_b[7:4];
  assign pin_sel[4] = sel_c[3:0];
  assign pin_sel[5] = sel_c[7:4];
  assign pin_sel[6] = sel_d[3:0];
  assign rx_cmos_in_en = cmos_all[4:2];
  assign rx_comp_in_en = comp_all[4:2];

  generate
    for (genvar i = 0; i < 7; i++)
    begin : g_pin
      serc_pin_mux #(.INPUT_CAPABLE(i >= 2 && i <= 4)) u_pin (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .sel     (pin_sel[i]),
        .src     (src),
        .pin_out (gpo_out[i]),
        .pin_oe  (gpo_oe[i]),
        .cmos_in (cmos_all[i]),
        .comp_in (comp_all[i])
      );
    end
  endgenerate

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  AST_PASS_UNMASKED: assert property (
    sf_in_valid && !aud_hide |=> aud_out.data == $past(sf_in.data))
    else $error("unmasked sub-frame altered");
  AST_ZERO_FILL: assert property (
    sf_in_valid && aud_hide && conceal_select |=> aud_valid && aud_out.data == 24'h0)
    else $error("zero fill missing");
  AST_HOLD_FILL: assert property (
    sf_in_valid && aud_hide && !conceal_select |=> aud_out.data == $past(held_sel))
    else $error("hold fill missing");
  AST_PASS_MARKED: assert property (
    sf_in_valid && pass_marked_samples && !sf_in.corrupt
    |=> aud_out.data == $past(sf_in.data))
    else $error("marked sample not passed");
  AST_TX_CORRUPT: assert property (
    sf_in_valid && !sf_in.invalid |=> tx_out.data == $past(sf_in.data))
    else $error("transmitter data replaced on corrupt flag");
  AST_INT_RAISE: assert property (
    sf_in_valid && sf_in.invalid && !mask[`SERC_MSK_INVALID] |=> !int_n)
    else $error("interrupt not raised");
  AST_INT_QUIET: assert property (
    int_n && ev == 3'b000 |=> int_n)
    else $error("interrupt without unmasked event");
  AST_NONPCM_EVT: assert property (
    $changed(burst_sync) && !$past(mask[`SERC_MSK_PCM_N]) |-> !int_n)
    else $error("burst sync change without interrupt");
  AST_SOFTMUTE: assert property (
    $past(first_dac_from_rx) && (nonpcm_status || burst_sync) |-> first_dac_softmute)
    else $error("first dac not softmuted");
  AST_BURST: assert property (
    found && !stat_in.unlock |=> burst_sync)
    else $error("sync code not flagged");
  AST_HELD: assert property (
    sf_in_valid && clean && sf_in.left |=> held[1] == $past(sf_in.data))
    else $error("held sample not updated");
  AST_GPO_V: assert property (
    pin_sel[0] == 4'h1 |=> gpo_out[0] == $past(stat_in.v))
    else $error("pin 1 not routed to V");
  AST_GPO_IN: assert property (
    reg_wr_en && reg_addr == `SERC_ADDR_SEL_B && reg_wr_data[3:0] == `SERC_SEL_CMOS_IN
    |=> ##1 rx_cmos_in_en[0] && !gpo_oe[2])
    else $error("pin 3 not set as input");

  COV_ZERO:  cover property (sf_in_valid && aud_hide && conceal_select);
  COV_HOLD:  cover property (sf_in_valid && aud_hide && !conceal_select);
  COV_BURST: cover property (found);
  COV_MUTE:  cover property (first_dac_softmute);

endmodule

/* File: tb/serc_src_model.sv */
// serc_src_model: recovered sub-frame source standing in for the decoder
// assumes the caller sends one sub-frame at a time on clk_sys
`timescale 1ns/100ps

module serc_src_model
  import serc_pkg::*;
(
  input  wire logic clk_sys,
  output logic      sf_in_valid,
  output serc_sub_s sf_in
);
  initial
  begin
    sf_in_valid = 1'b0;
    sf_in       = '0;
  end

  // one-cycle sub-frame; flags qualify only this sub-frame
  task automatic send(input logic [23:0] d, input logic l, input logic c, input logic i);
    @(posedge clk_sys);
    sf_in_valid <= 1'b1;
    sf_in       <= {d, l, c, i};
    @(posedge clk_sys);
    sf_in_valid <= 1'b0;
    // released bus carries scrambled data
    sf_in       <= ~{d, l, c, i};
  endtask
endmodule

/* File: tb/serc_conceal_bench.sv */
// serc_conceal_bench: register, concealment, non-audio and pin tests
// assumes the source model drives sub-frames, the bench drives the rest
`timescale 1ns/100ps
`include "serc_regs.svh"

module serc_conceal_bench
  import serc_pkg::*;
;
  localparam logic [15:0] PA = 16'hc3a1;
  localparam logic [15:0] PB = 16'h1e5d;
  logic clk_sys, reset_n, reg_wr_en, cs_nonaudio, first_dac_from_rx, int_clear;
  logic [6:0] reg_addr;
  logic [8:0] reg_wr_data, reg_rd_data;
  logic sf_in_valid, aud_valid, tx_valid, first_dac_softmute, nonpcm_status, burst_sync, int_n;
  serc_sub_s  sf_in;
  serc_stat_s stat_in;
  serc_pcm_s  aud_out, tx_out;
  logic [6:0] gpo_out, gpo_oe;
  logic [2:0] rx_cmos_in_en, rx_comp_in_en;
  int         bad_count;
  int         checks;
  int         idx;

  serc_src_model i_src (.clk_sys(clk_sys), .sf_in_valid(sf_in_valid), .sf_in(sf_in));

  serc_conceal #(.SYNC_PA(PA), .SYNC_PB(PB), .BURST_HOLD(13'd8)) i_dut
  (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .sf_in_valid(sf_in_valid),
    .sf_in(sf_in), .stat_in(stat_in), .cs_nonaudio(cs_nonaudio),
    .first_dac_from_rx(first_dac_from_rx), .int_clear(int_clear), .aud_valid(aud_valid),
    .aud_out(aud_out), .tx_valid(tx_valid), .tx_out(tx_out),
    .first_dac_softmute(first_dac_softmute), .nonpcm_status(nonpcm_status),
    .burst_sync(burst_sync), .int_n(int_n), .gpo_out(gpo_out), .gpo_oe(gpo_oe),
    .rx_cmos_in_en(rx_cmos_in_en), .rx_comp_in_en(rx_comp_in_en)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    if (bad_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    @(posedge clk_sys);
    reg_wr_en   <= 1'b1;
    reg_addr    <= a;
    reg_wr_data <= d;
    @(posedge clk_sys);
    reg_wr_en   <= 1'b0;
  endtask

  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic rd(input logic [6:0] a, input logic [8:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    settle();
    chk(32'(reg_rd_data), 32'(exp));
  endtask

  task automatic clr;
    @(posedge clk_sys);
    int_clear <= 1'b1;
    @(posedge clk_sys);
    int_clear <= 1'b0;
    #1;
  endtask

  task automatic cs_update(input logic na);
    @(posedge clk_sys);
    cs_nonaudio <= na;
    stat_in.chan_status_update <= 1'b1;
    @(posedge clk_sys);
    stat_in.chan_status_update <= 1'b0;
    settle();
  endtask

  task automatic sub(input logic [23:0] d, input logic l, input logic c, input logic i);
    i_src.send(d, l, c, i);
    #1;
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial
  begin
    #(50 * 5000);
    bad_count++;
    results();
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    bad_count = 0;
    checks = 0;
    reset_n = 1'b0;
    reg_wr_en = 1'b0;
    reg_addr = 7'h00;
    reg_wr_data = 9'h000;
    stat_in = '0;
    cs_nonaudio = 1'b0;
    first_dac_from_rx = 1'b0;
    int_clear = 1'b0;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(`SERC_ADDR_MASK, `SERC_RST_MASK);
    rd(`SERC_ADDR_SEL_A, `SERC_RST_SEL_A);
    rd(`SERC_ADDR_SEL_B, `SERC_RST_SEL_B);
    rd(`SERC_ADDR_SEL_C, `SERC_RST_SEL_C);
    rd(`SERC_ADDR_SEL_D, `SERC_RST_SEL_D);
    wr(7'h30, 9'h1ff);
    rd(7'h30, 9'h000);
    wr(`SERC_ADDR_SEL_D, 9'h1c7);
    rd(`SERC_ADDR_SEL_D, 9'h1c7);
    // unmasked corrupt and invalid sub-frame passes and interrupts
    sub(24'h123456, 1'b1, 1'b1, 1'b1);
    chk(32'(aud_out), 32'({24'h123456, 1'b1}));
    chk(32'(tx_out), 32'({24'h123456, 1'b1}));
    chk(32'(int_n), 32'(1'b0));
    clr();
    chk(32'(int_n), 32'(1'b1));
    // masked flags: hold last per side, then zero fill and marked pass
    wr(`SERC_ADDR_MASK, 9'h00a);
    sub(24'h111111, 1'b1, 1'b0, 1'b0);
    sub(24'h222222, 1'b0, 1'b0, 1'b0);
    sub(24'h0bad00, 1'b1, 1'b1, 1'b0);
    chk(32'(aud_out), 32'({24'h111111, 1'b1}));
    chk(32'(tx_out), 32'({24'h0bad00, 1'b1}));
    sub(24'h0bad01, 1'b0, 1'b0, 1'b1);
    chk(32'(aud_out), 32'({24'h222222, 1'b0}));
    chk(32'(tx_out), 32'({24'h222222, 1'b0}));
    chk(32'(int_n), 32'(1'b1));
    wr(`SERC_ADDR_SEL_A, 9'h110);
    sub(24'h0bad02, 1'b1, 1'b0, 1'b1);
    chk(32'(aud_out), 32'({24'h000000, 1'b1}));
    chk(32'(tx_out), 32'({24'h000000, 1'b1}));
    wr(`SERC_ADDR_SEL_B, 9'h132);
    sub(24'h333333, 1'b1, 1'b0, 1'b1);
    chk(32'(aud_out), 32'({24'h333333, 1'b1}));
    chk(32'(tx_out), 32'({24'h333333, 1'b1}));
    sub(24'h0bad03, 1'b0, 1'b1, 1'b0);
    chk(32'(aud_out), 32'({24'h000000, 1'b0}));
    // pin 1 source codes
    for (int k = 0; k < 14; k++)
    begin
      if (k == 9 || k == 11)
        continue;
      idx = (k <= 8) ? 11 - k : (k == 10) ? 2 : (k == 12) ? 1 : 0;
      wr(`SERC_ADDR_SEL_A, {5'h01, k[3:0]});
      @(posedge clk_sys);
      stat_in <= serc_stat_s'(11'h001 << idx);
      settle();
      chk(32'(gpo_out[0]), 32'(1'b1));
      stat_in <= serc_stat_s'(~(11'h001 << idx));
      settle();
      chk(32'(gpo_out[0]), 32'(k == 0));
      @(posedge clk_sys);
      stat_in <= '0;
    end
    // invalid flag source follows the sub-frame being taken
    wr(`SERC_ADDR_SEL_A, 9'h009);
    sub(24'h0bad04, 1'b0, 1'b0, 1'b1);
    chk(32'(gpo_out[0]), 32'(1'b1));
    sub(24'h0bad05, 1'b0, 1'b0, 1'b0);
    chk(32'(gpo_out[0]), 32'(1'b0));
    // input codes on pins three and four, refused on pin one
    wr(`SERC_ADDR_SEL_B, 9'h0fe);
    wr(`SERC_ADDR_SEL_A, 9'h00e);
    settle();
    chk(32'(rx_cmos_in_en), 32'(3'b001));
    chk(32'(rx_comp_in_en), 32'(3'b010));
    chk(32'({gpo_oe[3:2], gpo_oe[0], gpo_out[0]}), 32'(4'b0010));
    // non-audio status, unmasked then masked
    wr(`SERC_ADDR_MASK, 9'h000);
    first_dac_from_rx <= 1'b1;
    cs_update(1'b1);
    chk(32'({nonpcm_status, first_dac_softmute, int_n}), 32'(3'b110));
    wr(`SERC_ADDR_SEL_A, 9'h00b);
    settle();
    chk(32'(gpo_out[0]), 32'(1'b1));
    clr();
    wr(`SERC_ADDR_MASK, 9'h010);
    cs_update(1'b0);
    chk(32'({nonpcm_status, first_dac_softmute, int_n}), 32'(3'b001));
    cs_update(1'b1);
    chk(32'({nonpcm_status, first_dac_softmute, int_n}), 32'(3'b111));
    cs_update(1'b0);
    wr(`SERC_ADDR_MASK, 9'h000);
    // burst sync code across six sub-frames
    for (int k = 0; k < 6; k++)
      sub({(k == 4) ? PA : (k == 5) ? PB : 16'h0000, 8'h00}, k[0], 1'b0, 1'b0);
    chk(32'({burst_sync, first_dac_softmute, int_n}), 32'(3'b110));
    clr();
    @(posedge clk_sys);
    stat_in.unlock <= 1'b1;
    @(posedge clk_sys);
    stat_in.unlock <= 1'b0;
    settle();
    chk(32'({burst_sync, int_n}), 32'(2'b00));
    results();
  end
endmodule
